// ===== sie_consts.vh
// register map, field positions and reset values of the serial event block
`ifndef SIE_CONSTS_VH
`define SIE_CONSTS_VH
// register indices; byte address is four times the index
`define SIE_IDX_CTRL 16'hFFF0
`define SIE_IDX_STAT 16'hFFF1
`define SIE_IDX_CLKC 16'hFFF2
`define SIE_IDX_DATA 16'hFFF4
`define SIE_IDX_IRQ_STS 16'hFFF8
`define SIE_IDX_IRQ_CLR 16'hFFF9
`define SIE_IDX_IRQ_EN 16'hFFFA
// serial_control fields
`define SIE_CTRL_WDS_LO 0
`define SIE_CTRL_WDS_HI 2
`define SIE_CTRL_RE 8
`define SIE_CTRL_TE 9
`define SIE_CTRL_IDLE_LINE_IRQ_ENABLE 10
`define SIE_CTRL_RIE 11
`define SIE_CTRL_TIE 12
`define SIE_CTRL_BAUD_TIMER_IRQ_ENABLE 13
`define SIE_CTRL_CLOCK_POLARITY_SELECT 15
`define SIE_CTRL_RST 24'h000000
// serial_clock_control fields
`define SIE_CLKC_CD_LO 0
`define SIE_CLKC_CD_HI 11
`define SIE_CLKC_SCP 13
`define SIE_CLKC_TCM 14
`define SIE_CLKC_RCM 15
`define SIE_CLKC_RST 24'h000000
// serial_status fields
`define SIE_STAT_TX_HOLDING_EMPTY_FLAG 1
`define SIE_STAT_RX_HOLDING_FULL_FLAG 2
`define SIE_STAT_IDLE 3
`define SIE_STAT_OR 4
`define SIE_STAT_PE 5
`define SIE_STAT_FE 6
// event bits of the interrupt status, clear and enable registers
`define SIE_EV_RX 0
`define SIE_EV_RXERR 1
`define SIE_EV_TX 2
`define SIE_EV_IDLE 3
`define SIE_EV_TMR 4
`define SIE_IRQ_RST 5'h00
// counts
`define SIE_IDLE_ONES 4'hA
`define SIE_PRESCALE_BASE 6'h04
`define SIE_PRESCALE_SLOW 6'h20
`endif

// ===== sie_edge_sync.v
// two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
module sie_edge_sync (
  input wire ref_clk, // system clock
  input wire rst_b, // synchronous reset, active low
  input wire async_in, // level from outside the clock domain
  output wire level, // synchronised level
  output wire rise, // one-cycle pulse on a rising edge
  output wire fall // one-cycle pulse on a falling edge
);
  reg meta_ff;
  reg sync_ff;
  reg prev_ff;

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise = sync_ff & ~prev_ff;
  assign fall = ~sync_ff & prev_ff;
endmodule

// ===== sie_baud_timer.v
// baud rate counter: prescaler and 12-bit down counter with underflow pulse
`timescale 1ns/1ps
`include "sie_consts.vh"
module sie_baud_timer (
  input wire ref_clk, // system clock
  input wire rst_b, // synchronous reset, active low
  input wire [11:0] divider, // reload value of the down counter
  input wire slow, // extra divide by eight when set
  output reg underflow_ff // one-cycle pulse per underflow
);
  reg [5:0] pre_ff;
  reg [11:0] cnt_ff;
  wire [5:0] pre_top;
  wire pre_tick;

  // half a bit lasts 4 * (7*slow + 1) * (divider + 1) clocks
  assign pre_top = slow ? `SIE_PRESCALE_SLOW - 6'h01 : `SIE_PRESCALE_BASE - 6'h01;
  assign pre_tick = (pre_ff >= pre_top);

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      pre_ff <= 6'h00;
      cnt_ff <= 12'h000;
      underflow_ff <= 1'b0;
    end else begin
      underflow_ff <= 1'b0;
      if (pre_tick) begin
        pre_ff <= 6'h00;
        if (cnt_ff == 12'h000) begin
          cnt_ff <= divider;
          underflow_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 12'h001;
        end
      end else begin
        pre_ff <= pre_ff + 6'h01;
      end
    end
  end
endmodule

// ===== sie_core.v
// serial interface: synchronous slave shift path, flags, events and bus slave
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`include "sie_consts.vh"
module sie_core (
  input wire ref_clk, // system clock, 125 MHz
  input wire rst_b, // synchronous reset, active low
  input wire [17:0] avs_address, // byte address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  output reg [31:0] avs_readdata, // read data
  output wire avs_waitrequest, // stall
  input wire receive_bit_clock, // receive clock pin from the master
  input wire transmit_bit_clock, // transmit clock pin from the master
  input wire rxd, // serial data in
  output reg txd_ff, // serial data out
  input wire [4:0] irq_accept, // one-cycle accept per event source
  output wire irq // level interrupt
);
  reg [23:0] ctrl_ff;
  reg [23:0] clkc_ff;
  reg [7:0] tx_hold_ff;
  reg [7:0] rx_hold_ff;
  reg rx_holding_full_flag_ff;
  reg ovr_ff;
  reg tx_holding_empty_flag_ff;
  reg idle_ff;
  reg arm_ff;
  reg [4:0] irq_sts_ff;
  reg [4:0] irq_en_ff;
  reg [7:0] rx_sh_ff;
  reg [2:0] rx_cnt_ff;
  reg [3:0] ones_ff;
  reg [7:0] tx_word_ff;
  reg [7:0] tx_next_ff;
  reg [2:0] tx_cnt_ff;
  reg tx_run_ff;
  reg took_ff;
  reg int_clk_ff;
  reg rd_done_ff;
  reg [1:0] settle_ff;
  reg [31:0] nxt_readdata;
  reg [4:0] nxt_irq_sts;
  reg [4:0] ev;
  wire rxd_s;
  wire rxc_rise;
  wire rxc_fall;
  wire txc_rise;
  wire txc_fall;
  wire uf;
  wire int_rise;
  wire int_fall;
  wire shift_mode;
  wire clock_polarity_select;
  wire rx_smp;
  wire tx_drv;
  wire tx_mid;
  wire [7:0] rx_word;
  wire [15:0] idx;
  wire aligned;
  wire wr;
  wire rd;
  wire rd_stat;
  wire rd_data;
  wire wr_data;
  wire [4:0] gate;
  wire pins_ok;

  sie_edge_sync u_rxd (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(rxd),
    .level(rxd_s),
    .rise(),
    .fall()
  );

  sie_edge_sync u_rxc (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(receive_bit_clock),
    .level(),
    .rise(rxc_rise),
    .fall(rxc_fall)
  );

  sie_edge_sync u_txc (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(transmit_bit_clock),
    .level(),
    .rise(txc_rise),
    .fall(txc_fall)
  );

  sie_baud_timer u_baud (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .divider(clkc_ff[`SIE_CLKC_CD_HI:`SIE_CLKC_CD_LO]),
    .slow(clkc_ff[`SIE_CLKC_SCP]),
    .underflow_ff(uf)
  );

  // bus decode: registers take aligned words at four times their index
  assign idx = avs_address[17:2];
  assign aligned = (avs_address[1:0] == 2'b00);
  assign wr = avs_write & aligned;
  // reads complete one cycle after they are presented
  assign rd = avs_read & rd_done_ff & aligned;
  assign avs_waitrequest = avs_read & ~rd_done_ff;
  assign rd_stat = rd & (idx == `SIE_IDX_STAT);
  assign rd_data = rd & (idx == `SIE_IDX_DATA);
  assign wr_data = wr & (idx == `SIE_IDX_DATA);

  // internal bit clock: toggles on every baud underflow
  assign int_rise = uf & ~int_clk_ff;
  assign int_fall = uf & int_clk_ff;

  // synchronisers leave reset at zero, so a clock pin idling high would show a
  // false rise just after reset; pin edges count only once the flops have filled
  assign pins_ok = (settle_ff == 2'h3);
  assign shift_mode = (ctrl_ff[`SIE_CTRL_WDS_HI:`SIE_CTRL_WDS_LO] == 3'b000);
  assign clock_polarity_select = ctrl_ff[`SIE_CTRL_CLOCK_POLARITY_SELECT];
  // receive samples on the edge opposite the one transmit drives on; no edges means no shifting
  assign rx_smp = shift_mode & ctrl_ff[`SIE_CTRL_RE] &
    (clkc_ff[`SIE_CLKC_RCM] ? (pins_ok & (clock_polarity_select ? rxc_fall : rxc_rise))
                            : (clock_polarity_select ? int_fall : int_rise));
  assign tx_drv = shift_mode &
    (clkc_ff[`SIE_CLKC_TCM] ? (pins_ok & (clock_polarity_select ? txc_rise : txc_fall))
                            : (clock_polarity_select ? int_rise : int_fall));
  assign tx_mid = shift_mode &
    (clkc_ff[`SIE_CLKC_TCM] ? (pins_ok & (clock_polarity_select ? txc_fall : txc_rise))
                            : (clock_polarity_select ? int_fall : int_rise));
  assign rx_word = {rxd_s, rx_sh_ff[7:1]};

  // control enables gate the pending events onto the interrupt line
  assign gate = {ctrl_ff[`SIE_CTRL_BAUD_TIMER_IRQ_ENABLE], ctrl_ff[`SIE_CTRL_IDLE_LINE_IRQ_ENABLE], ctrl_ff[`SIE_CTRL_TIE],
                 ctrl_ff[`SIE_CTRL_RIE], ctrl_ff[`SIE_CTRL_RIE]};
  assign irq = |(irq_sts_ff & irq_en_ff & gate);

  // event pulses from the shift paths and the baud counter
  always @* begin
    ev = 5'h00;
    if (rx_smp && rx_cnt_ff == 3'h7) begin
      ev[`SIE_EV_RX] = ~rx_holding_full_flag_ff;
      ev[`SIE_EV_RXERR] = rx_holding_full_flag_ff;
    end
    ev[`SIE_EV_TX] = tx_mid & tx_run_ff & took_ff & (tx_cnt_ff == 3'h1);
    ev[`SIE_EV_IDLE] = rx_smp & rxd_s & (ones_ff == `SIE_IDLE_ONES - 4'h1);
    ev[`SIE_EV_TMR] = uf;
  end

  // sticky event bits: a new event wins over a clear in the same cycle
  always @* begin
    nxt_irq_sts = irq_sts_ff & ~irq_accept;
    if (wr && idx == `SIE_IDX_IRQ_CLR) begin
      nxt_irq_sts = nxt_irq_sts & ~avs_writedata[4:0];
    end
    nxt_irq_sts = nxt_irq_sts | ev;
  end

  always @* begin
    nxt_readdata = 32'h00000000;
    case (idx)
      `SIE_IDX_CTRL: nxt_readdata = {8'h00, ctrl_ff};
      `SIE_IDX_STAT: begin
        nxt_readdata[`SIE_STAT_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag_ff;
        nxt_readdata[`SIE_STAT_RX_HOLDING_FULL_FLAG] = rx_holding_full_flag_ff;
        nxt_readdata[`SIE_STAT_IDLE] = idle_ff;
        nxt_readdata[`SIE_STAT_OR] = ovr_ff;
        // no start or stop bits in shift mode, so parity and framing cannot fail
        nxt_readdata[`SIE_STAT_PE] = 1'b0;
        nxt_readdata[`SIE_STAT_FE] = 1'b0;
      end
      `SIE_IDX_CLKC: nxt_readdata = {8'h00, clkc_ff};
      `SIE_IDX_DATA: nxt_readdata = {24'h000000, rx_hold_ff};
      `SIE_IDX_IRQ_STS: nxt_readdata = {27'h0000000, irq_sts_ff};
      `SIE_IDX_IRQ_EN: nxt_readdata = {27'h0000000, irq_en_ff};
      default: nxt_readdata = 32'h00000000;
    endcase
    if (!aligned) begin
      nxt_readdata = 32'h00000000;
    end
  end

  // bus side registers
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      ctrl_ff <= `SIE_CTRL_RST;
      clkc_ff <= `SIE_CLKC_RST;
      irq_en_ff <= `SIE_IRQ_RST;
      irq_sts_ff <= `SIE_IRQ_RST;
      avs_readdata <= 32'h00000000;
      rd_done_ff <= 1'b0;
      int_clk_ff <= 1'b0;
      settle_ff <= 2'h0;
    end else begin
      rd_done_ff <= avs_read & ~rd_done_ff;
      if (!pins_ok) begin
        settle_ff <= settle_ff + 2'h1;
      end
      if (avs_read && !rd_done_ff) begin
        avs_readdata <= nxt_readdata;
      end
      irq_sts_ff <= nxt_irq_sts;
      if (uf) begin
        int_clk_ff <= ~int_clk_ff;
      end
      if (wr && idx == `SIE_IDX_CTRL) begin
        ctrl_ff <= avs_writedata[23:0];
      end
      if (wr && idx == `SIE_IDX_CLKC) begin
        clkc_ff <= avs_writedata[23:0];
      end
      if (wr && idx == `SIE_IDX_IRQ_EN) begin
        irq_en_ff <= avs_writedata[4:0];
      end
    end
  end

  // receiver: free-running bit count, since no frame marks word starts
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      rx_sh_ff <= 8'h00;
      rx_cnt_ff <= 3'h0;
      rx_hold_ff <= 8'h00;
      rx_holding_full_flag_ff <= 1'b0;
      ovr_ff <= 1'b0;
      arm_ff <= 1'b0;
      ones_ff <= 4'h0;
      idle_ff <= 1'b0;
    end else begin
      if (!ctrl_ff[`SIE_CTRL_RE]) begin
        rx_cnt_ff <= 3'h0;
      end else if (rx_smp) begin
        rx_sh_ff <= rx_word;
        rx_cnt_ff <= rx_cnt_ff + 3'h1;
      end
      if (rx_smp) begin
        if (!rxd_s) begin
          ones_ff <= 4'h0;
          idle_ff <= 1'b0;
        end else if (ones_ff != `SIE_IDLE_ONES) begin
          ones_ff <= ones_ff + 4'h1;
          if (ones_ff == `SIE_IDLE_ONES - 4'h1) begin
            idle_ff <= 1'b1;
          end
        end
      end
      // only a status read that saw the error arms its clear
      if (rd_stat) begin
        arm_ff <= ovr_ff;
      end else if (rd_data) begin
        arm_ff <= 1'b0;
      end
      // the unread word is kept; the late one is dropped and flagged
      if (rd_data) begin
        rx_holding_full_flag_ff <= 1'b0;
        if (arm_ff) begin
          ovr_ff <= 1'b0;
        end
      end
      if (ev[`SIE_EV_RX]) begin
        rx_hold_ff <= rx_word;
        rx_holding_full_flag_ff <= 1'b1;
      end
      if (ev[`SIE_EV_RXERR]) begin
        ovr_ff <= 1'b1;
        rx_holding_full_flag_ff <= 1'b1;
      end
    end
  end

  // transmitter: words follow back to back while the bit clock runs
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      tx_hold_ff <= 8'h00;
      tx_holding_empty_flag_ff <= 1'b1;
      tx_word_ff <= 8'h00;
      tx_next_ff <= 8'h00;
      tx_cnt_ff <= 3'h0;
      tx_run_ff <= 1'b0;
      took_ff <= 1'b0;
      txd_ff <= 1'b1;
    end else begin
      if (wr_data) begin
        tx_hold_ff <= avs_writedata[7:0];
        tx_holding_empty_flag_ff <= 1'b0;
      end
      if (ev[`SIE_EV_TX]) begin
        tx_holding_empty_flag_ff <= 1'b1;
        took_ff <= 1'b0;
      end
      if (!ctrl_ff[`SIE_CTRL_TE]) begin
        tx_run_ff <= 1'b0;
        tx_cnt_ff <= 3'h0;
        txd_ff <= 1'b1;
      end else if (tx_drv) begin
        if (!tx_run_ff) begin
          if (!tx_holding_empty_flag_ff) begin
            tx_word_ff <= tx_hold_ff;
            txd_ff <= tx_hold_ff[0];
            tx_cnt_ff <= 3'h0;
            tx_run_ff <= 1'b1;
            took_ff <= 1'b1;
          end
        end else if (tx_cnt_ff == 3'h7) begin
          tx_word_ff <= tx_next_ff;
          txd_ff <= tx_next_ff[0];
          tx_cnt_ff <= 3'h0;
        end else begin
          txd_ff <= tx_word_ff[tx_cnt_ff + 3'h1];
          tx_cnt_ff <= tx_cnt_ff + 3'h1;
        end
      end else if (tx_mid && tx_run_ff && tx_cnt_ff == 3'h6) begin
        // last chance for a new word; otherwise the current one repeats
        if (!tx_holding_empty_flag_ff) begin
          tx_next_ff <= tx_hold_ff;
          took_ff <= 1'b1;
        end else begin
          tx_next_ff <= tx_word_ff;
        end
      end
    end
  end
endmodule

// ===== sie_core_properties.sv
// concurrent checks on the serial event block's ports
`timescale 1ns/1ps
`include "sie_consts.vh"
module sie_core_properties (
  input wire ref_clk, // system clock
  input wire rst_b, // reset, active low
  input wire [17:0] avs_address, // byte address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  input wire [31:0] avs_readdata, // read data
  input wire avs_waitrequest, // stall
  input wire receive_bit_clock, // receive clock pin
  input wire transmit_bit_clock, // transmit clock pin
  input wire rxd, // serial in
  input wire txd_ff, // serial out
  input wire [4:0] irq_accept, // event accepts
  input wire irq // interrupt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic tclk_d_ff;
  logic [3:0] quiet_ff;
  // a bus write may switch the transmitter off, so it restarts the quiet count
  always @(posedge ref_clk) begin
    tclk_d_ff <= transmit_bit_clock;
    if (!rst_b || avs_write || transmit_bit_clock != tclk_d_ff)
      quiet_ff <= 4'h0;
    else if (quiet_ff != 4'hF)
      quiet_ff <= quiet_ff + 4'h1;
  end
  write_no_wait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  read_one_wait_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read stalled past one cycle");
  read_first_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered without wait");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  unaligned_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address[1:0] != 2'b00 |-> avs_readdata == 32'h0) else $error("unaligned read not zero");
  irq_mask_off_a: assert property (avs_write && avs_address == {`SIE_IDX_IRQ_EN, 2'b00} &&
    avs_writedata[4:0] == 5'h00 |=> !irq) else $error("irq with sources masked");
  irq_gate_off_a: assert property (avs_write &&
    avs_address == {`SIE_IDX_CTRL, 2'b00} && avs_writedata[13:10] == 4'h0 |=> !irq)
    else $error("irq with gates off");
  txd_hold_a: assert property (quiet_ff >= 4'h8 |-> $stable(txd_ff))
    else $error("serial out moved without clock");
  reset_idle_a: assert property ($rose(rst_b) |-> txd_ff && !irq)
    else $error("not idle after reset");
  cover property ($rose(irq));
  cover property (avs_read && !avs_waitrequest);
  cover property ($fell(txd_ff));
endmodule
bind sie_core sie_core_properties chk_u (.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .receive_bit_clock, .transmit_bit_clock,
  .rxd, .txd_ff, .irq_accept, .irq);

// ===== sie_link_master.sv
// external synchronous master: one bit clock for both directions, data in and out
`timescale 1ns/1ps
module sie_link_master (
  output logic bit_clk, // bit clock to both clock pins
  output logic rxd_o, // serial data toward the block
  input wire txd_i // serial data from the block
);
  logic [7:0] rx_q[$];
  logic [7:0] tx_q[$];
  initial begin
    bit_clk = 1'b1;
    rxd_o = 1'b1;
  end
  // idle level sits on the sample edge side; wait so the move is not taken as a bit
  task automatic park(input logic pol);
    bit_clk = ~pol;
    #100;
  endtask
  // clock runs only within frames, words back to back, lsb first
  task automatic frame(input logic pol, input int words);
    logic [7:0] w;
    logic [7:0] t;
    #3;
    for (int k = 0; k < words; k++) begin
      w = rx_q.pop_front();
      for (int i = 0; i < 8; i++) begin
        bit_clk = pol;
        rxd_o = w[i];
        #80;
        bit_clk = ~pol;
        t[i] = txd_i;
        #80;
      end
      tx_q.push_back(t);
    end
    rxd_o = ~rxd_o;
  endtask
endmodule

// ===== sie_core_tb.sv
// self-checking bench for the serial event block
`timescale 1ns/1ps
`include "sie_consts.vh"
module sie_core_tb;
  logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest, txd_ff, irq, bit_clk, rxd;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, ctl;
  logic [4:0] irq_accept;
  logic [7:0] a, b, r0;
  logic [7:0] exp_tx[$];
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  int per;
  sie_core dut_u (.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .receive_bit_clock(bit_clk), .transmit_bit_clock(bit_clk),
    .rxd, .txd_ff, .irq_accept, .irq);
  sie_link_master master_u (.bit_clk(bit_clk), .rxd_o(rxd), .txd_i(txd_ff));
  function automatic [17:0] ba(input [15:0] idx);
    ba = {idx, 2'b00};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic bus(input logic wr, input logic [17:0] adr, input logic [31:0] wd);
    @(posedge ref_clk);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge ref_clk);
    while (avs_waitrequest) @(posedge ref_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic summarize;
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 18'h00000;
    avs_writedata = 32'h0;
    irq_accept = 5'h00;
    void'($urandom(51222));
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    bus(0, ba(`SIE_IDX_CTRL), 0);
    chk("control reset", 32'h0, rd);
    bus(0, ba(`SIE_IDX_IRQ_EN), 0);
    chk("irq enable reset", 32'h0, rd);
    bus(1, ba(`SIE_IDX_STAT), 32'hFF);
    bus(0, ba(`SIE_IDX_STAT), 0);
    chk("status reset", 32'h2, rd);
    bus(0, ba(16'hFFF3), 0);
    chk("unmapped read", 32'h0, rd);
    bus(0, ba(`SIE_IDX_CTRL) | 18'h2, 0);
    chk("unaligned read", 32'h0, rd);
    bus(1, ba(`SIE_IDX_CLKC), 32'h00C003);
    bus(0, ba(`SIE_IDX_CLKC), 0);
    chk("clock control", 32'h00C003, rd);
    bus(1, ba(`SIE_IDX_IRQ_EN), 32'h07);
    for (int p = 0; p < 2; p++) begin
      for (int late = 0; late < 2; late++) begin
        ctl = 32'h1B00 | (32'(p) << 15);
        bus(1, ba(`SIE_IDX_CTRL), 32'h0);
        master_u.park(p[0]);
        bus(1, ba(`SIE_IDX_CTRL), ctl);
        bus(1, ba(`SIE_IDX_IRQ_CLR), 32'h1F);
        a = 8'($urandom);
        b = 8'($urandom);
        r0 = 8'($urandom) & 8'h7F;
        master_u.rx_q.push_back(r0);
        master_u.rx_q.push_back(late ? 8'hFF : 8'($urandom));
        if (late) master_u.rx_q.push_back(8'hFF);
        exp_tx = {a};
        if (late) exp_tx.push_back(a);
        exp_tx.push_back(b);
        bus(1, ba(`SIE_IDX_DATA), {24'h0, a});
        fork
          master_u.frame(p[0], late + 2);
          begin
            #(late ? 1100 : 500);
            bus(1, ba(`SIE_IDX_DATA), {24'h0, b});
          end
        join
        foreach (exp_tx[i]) chk("sent word", exp_tx[i], master_u.tx_q.pop_front());
        chk("irq line", 1, irq);
        bus(0, ba(`SIE_IDX_IRQ_STS), 0);
        chk("events", {late[0], 3'b111}, rd[3:0]);
        if (late) bus(0, ba(`SIE_IDX_DATA), 0);
        bus(0, ba(`SIE_IDX_STAT), 0);
        chk("status", late ? 32'h1A : 32'h16, rd);
        bus(0, ba(`SIE_IDX_DATA), 0);
        chk("received word", {24'h0, r0}, rd);
        bus(0, ba(`SIE_IDX_STAT), 0);
        chk("status cleared", 32'h2 | 32'(late << 3), rd);
        bus(1, ba(`SIE_IDX_IRQ_CLR), 32'h1F);
        #1 chk("irq cleared", 0, irq);
      end
    end
    per = 4 * (3 + 1);
    bus(1, ba(`SIE_IDX_IRQ_EN), 32'h10);
    bus(1, ba(`SIE_IDX_CTRL), 32'h2000);
    bus(1, ba(`SIE_IDX_IRQ_CLR), 32'h10);
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk("timer irq", 1, irq);
    irq_accept <= 5'h10;
    @(posedge ref_clk);
    irq_accept <= 5'h00;
    #1 chk("timer accepted", 0, irq);
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk("timer period", 1, n >= per - 3 && n <= per + 1);
    bus(1, ba(`SIE_IDX_IRQ_EN), 32'h0);
    #1 chk("irq masked", 0, irq);
    bus(0, ba(`SIE_IDX_IRQ_STS), 0);
    chk("timer sticky", 1, rd[4]);
    bus(1, ba(`SIE_IDX_IRQ_CLR), 32'h1F);
    bus(1, ba(`SIE_IDX_DATA), 32'hFF);
    bus(1, ba(`SIE_IDX_CLKC), 32'h000003);
    bus(1, ba(`SIE_IDX_CTRL), 32'h0201);
    repeat (150) @(posedge ref_clk);
    bus(0, ba(`SIE_IDX_IRQ_STS), 0);
    chk("no shift outside format zero", 0, rd[2]);
    bus(1, ba(`SIE_IDX_CTRL), 32'h0200);
    repeat (150) @(posedge ref_clk);
    bus(0, ba(`SIE_IDX_IRQ_STS), 0);
    chk("internal clock tx event", 1, rd[2]);
    bus(0, ba(`SIE_IDX_STAT), 0);
    chk("internal clock tx empty", 1, rd[1]);
    summarize();
  end
endmodule
